// File: logic/cmd_scale_sat.v
// Shift-and-saturate scaler from filter sum onto the signed analog command code
`timescale 1ns/1ps

module cmd_scale_sat #(
    parameter IN_W = 52,
    parameter OUT_W = 16,
    parameter SHIFT = 8
) (
    input wire signed [IN_W-1:0] sum_in,
    output reg signed [OUT_W-1:0] code_out
);

    // ----------------------------------------
    // Scale and clamp
    // ----------------------------------------
    localparam signed [IN_W-1:0] MAX_CODE = (1 <<< (OUT_W - 1)) - 1;
    localparam signed [IN_W-1:0] MIN_CODE = -(1 <<< (OUT_W - 1));

    wire signed [IN_W-1:0] shifted;

    assign shifted = sum_in >>> SHIFT;

    always @* begin
        if (shifted > MAX_CODE) begin
            code_out = MAX_CODE[OUT_W-1:0];
        end else if (shifted < MIN_CODE) begin
            code_out = MIN_CODE[OUT_W-1:0];
        end else begin
            code_out = shifted[OUT_W-1:0];
        end
    end

endmodule // cmd_scale_sat

// File: logic/servo_axis_filter_loop.v
// Servo axis filter loop: error filter, holding modes, profile parameters and register port
`timescale 1ns/1ps
`include "servo_map.vh"

module servo_axis_filter_loop #(
    parameter POS_W = 32,
    parameter FF_W = 16,
    parameter DAC_W = 16,
    parameter SCALE_SHIFT = 8,
    parameter UPDATE_CYCLES = `UPDATE_CYCLES
) (
    input wire ref_clk,
    input wire rst,
    input wire [15:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_r,
    output reg reg_rvalid_r,
    input wire prof_valid,
    input wire prof_has_speed,
    input wire [31:0] prof_speed,
    input wire prof_has_accel,
    input wire [31:0] prof_accel,
    input wire prof_has_gains,
    input wire [7:0] prof_p_gain,
    input wire [7:0] prof_i_gain,
    input wire [7:0] prof_d_gain,
    input wire prof_has_hold,
    input wire [1:0] prof_hold_mode,
    input wire [31:0] prof_deadband,
    input wire decel_wr,
    input wire [31:0] decel_wdata,
    input wire move_req,
    input wire move_done,
    input wire signed [POS_W-1:0] actual_pos,
    input wire signed [POS_W-1:0] intended_pos,
    input wire signed [POS_W-1:0] intended_vel,
    output reg signed [DAC_W-1:0] dac_code_r,
    output reg cmd_update_r,
    output reg move_start_r,
    output reg not_ready_fault_r,
    output reg [31:0] max_speed_r,
    output reg [31:0] accel_r,
    output reg [31:0] decel_r
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    localparam SUM_W = 2 * POS_W + 4;
    localparam CNT_W = 24;
    localparam integer TICK_LAST_I = UPDATE_CYCLES - 1;
    localparam [CNT_W-1:0] TICK_LAST = TICK_LAST_I[CNT_W-1:0];
    localparam [1:0] S_UNPROF = 2'h0;
    localparam [1:0] S_REST = 2'h1;
    localparam [1:0] S_MOVE = 2'h2;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [CNT_W-1:0] tick_cnt_r;
    reg tick_r;
    reg [1:0] axis_state_r;
    reg [1:0] axis_state_nxt;
    reg [31:0] filter_sel_r;
    reg [31:0] vel_ff_gain_r;
    reg [31:0] acc_ff_gain_r;
    reg [1:0] active_mode_r;
    reg [1:0] hold_mode_r;
    reg [31:0] deadband_r;
    reg [7:0] p_gain_r;
    reg [7:0] i_gain_r;
    reg [7:0] d_gain_r;
    reg signed [POS_W-1:0] last_err_r;
    reg signed [POS_W-1:0] cum_err_r;
    reg signed [POS_W-1:0] last_vel_r;
    reg [1:0] sel_mode;
    reg quiet;
    reg signed [SUM_W-1:0] filter_sum;
    reg signed [DAC_W-1:0] direct_code;
    reg [31:0] direct_mag;
    reg [31:0] state_word;

    wire signed [POS_W-1:0] pos_err;
    wire signed [POS_W:0] err_delta;
    wire signed [POS_W:0] vel_delta;
    wire [POS_W-1:0] abs_err;
    wire signed [SUM_W-1:0] p_term;
    wire signed [SUM_W-1:0] d_term;
    wire signed [SUM_W-1:0] i_term;
    wire signed [SUM_W-1:0] aff_term;
    wire signed [SUM_W-1:0] vff_term;
    wire signed [DAC_W-1:0] scaled_code;
    wire profiled;

    // ----------------------------------------
    // Update-rate tick
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            tick_cnt_r <= {CNT_W{1'b0}};
            tick_r <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= {CNT_W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Filter terms
    // ----------------------------------------
    assign pos_err = actual_pos - intended_pos;
    assign err_delta = {pos_err[POS_W-1], pos_err} - {last_err_r[POS_W-1], last_err_r};
    assign vel_delta = {intended_vel[POS_W-1], intended_vel} - {last_vel_r[POS_W-1], last_vel_r};
    assign abs_err = pos_err[POS_W-1] ? (~pos_err + {{(POS_W-1){1'b0}}, 1'b1}) : pos_err;
    assign p_term = pos_err * $signed({1'b0, p_gain_r});
    assign d_term = err_delta * $signed({1'b0, d_gain_r});
    assign i_term = cum_err_r * $signed({1'b0, i_gain_r});
    assign aff_term = vel_delta * $signed({1'b0, acc_ff_gain_r[FF_W-1:0]});
    assign vff_term = intended_vel * $signed({1'b0, vel_ff_gain_r[FF_W-1:0]});
    assign profiled = (axis_state_r != S_UNPROF);

    always @* begin
        if (active_mode_r == `MODE_FEEDFWD) begin
            filter_sum = p_term + aff_term + vff_term;
        end else begin
            filter_sum = p_term + d_term + i_term;
        end
    end

    cmd_scale_sat #(
        .IN_W(SUM_W),
        .OUT_W(DAC_W),
        .SHIFT(SCALE_SHIFT)
    ) u_scale (
        .sum_in(filter_sum),
        .code_out(scaled_code)
    );

    // ----------------------------------------
    // Direct drive and holding decisions
    // ----------------------------------------
    always @* begin
        if (vel_ff_gain_r > `DIRECT_MAX) begin
            direct_mag = `DIRECT_MAX;
        end else begin
            direct_mag = vel_ff_gain_r;
        end
        if (active_mode_r == `MODE_DIRECT_NEG) begin
            direct_code = -$signed(direct_mag[DAC_W-1:0]);
        end else begin
            direct_code = $signed(direct_mag[DAC_W-1:0]);
        end
    end

    always @* begin
        if (axis_state_r == S_UNPROF) begin
            quiet = 1'b1;
        end else if (axis_state_r == S_MOVE) begin
            quiet = 1'b0;
        end else if (hold_mode_r == `HOLD_OFF) begin
            quiet = 1'b1;
        end else if (hold_mode_r == `HOLD_DEADBAND) begin
            quiet = (abs_err <= deadband_r);
        end else begin
            quiet = 1'b0;
        end
    end

    always @* begin
        case (filter_sel_r)
            `FSEL_FEEDFWD: sel_mode = `MODE_FEEDFWD;
            `FSEL_DIRECT_NEG: sel_mode = `MODE_DIRECT_NEG;
            `FSEL_DIRECT_POS: sel_mode = `MODE_DIRECT_POS;
            default: sel_mode = `MODE_PID;
        endcase
    end

    // ----------------------------------------
    // Loop update
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            dac_code_r <= {DAC_W{1'b0}};
            cmd_update_r <= 1'b0;
            last_err_r <= {POS_W{1'b0}};
            cum_err_r <= {POS_W{1'b0}};
            last_vel_r <= {POS_W{1'b0}};
        end else begin
            cmd_update_r <= tick_r;
            if (tick_r) begin
                if (quiet) begin
                    dac_code_r <= {DAC_W{1'b0}};
                end else if (active_mode_r[1]) begin
                    dac_code_r <= direct_code;
                end else begin
                    dac_code_r <= scaled_code;
                end
                last_err_r <= pos_err;
                last_vel_r <= intended_vel;
                if (!quiet && active_mode_r == `MODE_PID) begin
                    cum_err_r <= cum_err_r + pos_err;
                end
            end
        end
    end

    // ----------------------------------------
    // Axis state and profile handling
    // ----------------------------------------
    always @* begin
        case (axis_state_r)
            S_UNPROF: axis_state_nxt = prof_valid ? S_REST : S_UNPROF;
            S_REST: axis_state_nxt = move_req ? S_MOVE : S_REST;
            S_MOVE: axis_state_nxt = move_done ? S_REST : S_MOVE;
            default: axis_state_nxt = S_UNPROF;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            axis_state_r <= S_UNPROF;
            move_start_r <= 1'b0;
            not_ready_fault_r <= 1'b0;
            active_mode_r <= `MODE_PID;
            hold_mode_r <= `HOLD_AT_POS;
            deadband_r <= 32'h00000000;
            p_gain_r <= `RST_P_GAIN;
            i_gain_r <= 8'h00;
            d_gain_r <= 8'h00;
            max_speed_r <= `RST_SPEED;
            accel_r <= `RST_SPEED;
            decel_r <= `RST_SPEED;
        end else begin
            axis_state_r <= axis_state_nxt;
            move_start_r <= move_req && profiled;
            if (move_req && !profiled) begin
                not_ready_fault_r <= 1'b1;
            end else if (prof_valid) begin
                not_ready_fault_r <= 1'b0;
            end
            if (prof_valid) begin
                if (axis_state_r == S_UNPROF) begin
                    active_mode_r <= sel_mode;
                end
                if (prof_has_speed) begin
                    max_speed_r <= prof_speed;
                end
                if (prof_has_gains) begin
                    p_gain_r <= (prof_p_gain < `P_GAIN_MIN) ? `P_GAIN_MIN : prof_p_gain;
                    i_gain_r <= prof_i_gain;
                    d_gain_r <= prof_d_gain;
                end
                if (prof_has_hold) begin
                    hold_mode_r <= (prof_hold_mode > `HOLD_OFF) ? `HOLD_AT_POS : prof_hold_mode;
                    deadband_r <= prof_deadband;
                end
            end
            if (prof_valid && prof_has_accel) begin
                accel_r <= prof_accel;
                decel_r <= prof_accel;
            end else if (decel_wr) begin
                decel_r <= decel_wdata;
            end
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always @* begin
        state_word = 32'h00000000;
        state_word[`ST_PROFILED] = profiled;
        state_word[`ST_AT_REST] = (axis_state_r == S_REST);
        state_word[`ST_NOT_READY] = not_ready_fault_r;
        state_word[`ST_MOVING] = (axis_state_r == S_MOVE);
        state_word[`ST_MODE_MSB:`ST_MODE_LSB] = active_mode_r;
        state_word[`ST_HOLD_MSB:`ST_HOLD_LSB] = hold_mode_r;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            filter_sel_r <= `RST_FILTER_SEL;
            vel_ff_gain_r <= `RST_FF_GAIN;
            acc_ff_gain_r <= `RST_FF_GAIN;
            reg_rdata_r <= 32'h00000000;
            reg_rvalid_r <= 1'b0;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `ADDR_FILTER_SEL: filter_sel_r <= reg_wdata;
                    `ADDR_VEL_FF_GAIN: vel_ff_gain_r <= reg_wdata;
                    `ADDR_ACC_FF_GAIN: acc_ff_gain_r <= reg_wdata;
                    default: filter_sel_r <= filter_sel_r;
                endcase
            end
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_MOTION_STATE: reg_rdata_r <= state_word;
                    `ADDR_FILTER_SEL: reg_rdata_r <= filter_sel_r;
                    `ADDR_VEL_FF_GAIN: reg_rdata_r <= vel_ff_gain_r;
                    `ADDR_ACC_FF_GAIN: reg_rdata_r <= acc_ff_gain_r;
                    default: reg_rdata_r <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // servo_axis_filter_loop

// File: shared/servo_map.vh
// Offsets, fields, reset values and timing counts of the servo axis filter loop
`ifndef SERVO_MAP_VH
`define SERVO_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_MOTION_STATE 16'h37dd
`define ADDR_VEL_FF_GAIN 16'h38a5
`define ADDR_ACC_FF_GAIN 16'h39d1
`define ADDR_FILTER_SEL 16'h4269

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FILTER_SEL 32'h00000000
`define RST_FF_GAIN 32'h00000000
`define RST_P_GAIN 8'h01
`define RST_SPEED 32'h00000000

// ----------------------------------------
// Filter select codes
// ----------------------------------------
`define FSEL_DIRECT_NEG 32'h00000001
`define FSEL_DIRECT_POS 32'h00000002
`define FSEL_FEEDFWD 32'h00000005

// ----------------------------------------
// Active loop modes
// ----------------------------------------
`define MODE_PID 2'h0
`define MODE_FEEDFWD 2'h1
`define MODE_DIRECT_NEG 2'h2
`define MODE_DIRECT_POS 2'h3

// ----------------------------------------
// Holding modes
// ----------------------------------------
`define HOLD_AT_POS 2'h0
`define HOLD_DEADBAND 2'h1
`define HOLD_OFF 2'h2

// ----------------------------------------
// Motion state fields
// ----------------------------------------
`define ST_PROFILED 0
`define ST_AT_REST 1
`define ST_NOT_READY 2
`define ST_MOVING 3
`define ST_MODE_LSB 4
`define ST_MODE_MSB 5
`define ST_HOLD_LSB 6
`define ST_HOLD_MSB 7

// ----------------------------------------
// Gains and direct drive
// ----------------------------------------
`define P_GAIN_MIN 8'h01
`define DIRECT_MAX 32'h00007fff

// ----------------------------------------
// Update timing
// ----------------------------------------
`define CLK_RATE_HZ 25000000
`define UPDATE_RATE_HZ 2048
`define UPDATE_CYCLES (`CLK_RATE_HZ / `UPDATE_RATE_HZ)

`endif

// File: testbench/servo_axis_filter_loop_monitor.sv
// Port checker for the servo axis filter loop
`timescale 1ns/1ps

module servo_axis_filter_loop_monitor #(
    parameter UPDATE_CYCLES = 20
) (
    input wire ref_clk,
    input wire rst,
    input wire prof_valid,
    input wire prof_has_accel,
    input wire [31:0] prof_accel,
    input wire decel_wr,
    input wire [31:0] decel_wdata,
    input wire move_req,
    input wire move_start_r,
    input wire not_ready_fault_r,
    input wire [31:0] accel_r,
    input wire [31:0] decel_r,
    input wire signed [15:0] dac_code_r,
    input wire cmd_update_r
);
    // --------------------
    // Cycles since last update
    // --------------------
    reg [15:0] gap_r;
    always @(posedge ref_clk) begin
        if (rst || cmd_update_r) begin
            gap_r <= 16'h0;
        end else begin
            gap_r <= gap_r + 16'h1;
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence quiet_s;
        ##1 (!cmd_update_r) [*8];
    endsequence

    // --------------------
    // Assertions
    // --------------------
    upd_gap_a: assert property (gap_r <= UPDATE_CYCLES + 1)
        else $error("Command update overdue");
    upd_period_a: assert property (cmd_update_r |-> gap_r >= UPDATE_CYCLES - 1)
        else $error("Command update came too early");
    upd_space_a: assert property (cmd_update_r |-> quiet_s)
        else $error("Command update not a lone pulse");
    dac_hold_a: assert property ($changed(dac_code_r) |-> cmd_update_r)
        else $error("Command code moved between updates");
    fault_hold_a: assert property (not_ready_fault_r && !prof_valid |=> not_ready_fault_r)
        else $error("Fault cleared without profile");
    move_ans_a: assert property (move_req && !prof_valid |=> move_start_r != not_ready_fault_r)
        else $error("Move neither started nor faulted");
    decel_follow_a: assert property (prof_valid && prof_has_accel |=>
        accel_r == $past(prof_accel) && decel_r == $past(prof_accel))
        else $error("Accel did not set both ramps");
    decel_write_a: assert property (decel_wr && !(prof_valid && prof_has_accel) |=>
        decel_r == $past(decel_wdata))
        else $error("Decel write not taken");
    ramp_keep_a: assert property (prof_valid && !prof_has_accel && !decel_wr |=>
        $stable(accel_r) && $stable(decel_r))
        else $error("Omitted ramp changed");
endmodule // servo_axis_filter_loop_monitor

bind servo_axis_filter_loop servo_axis_filter_loop_monitor #(.UPDATE_CYCLES(UPDATE_CYCLES)) mon_u (.ref_clk, .rst,
    .prof_valid, .prof_has_accel, .prof_accel, .decel_wr, .decel_wdata, .move_req, .move_start_r,
    .not_ready_fault_r, .accel_r, .decel_r, .dac_code_r, .cmd_update_r);

// File: testbench/servo_axis_filter_loop_test.sv
// Self-checking testbench for the servo axis filter loop
`timescale 1ns/1ps
`include "servo_map.vh"

module servo_axis_filter_loop_test;
    localparam UC = 20;
    reg ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, prof_valid = 1'b0, decel_wr = 1'b0;
    reg move_req = 1'b0, move_done = 1'b0, set_en = 1'b0;
    reg prof_has_speed = 1'b0, prof_has_accel = 1'b0, prof_has_gains = 1'b0, prof_has_hold = 1'b0;
    reg [15:0] reg_addr = 16'h0;
    reg [31:0] reg_wdata = 32'h0, decel_wdata = 32'h0, prof_speed = 32'h0, prof_accel = 32'h0, prof_deadband = 32'h0;
    reg [7:0] prof_p_gain = 8'h1, prof_i_gain = 8'h3, prof_d_gain = 8'h7;
    reg [1:0] prof_hold_mode = 2'h0;
    reg signed [31:0] intended_pos = 32'sh0, intended_vel = 32'sh64, set_val = 32'sh0;
    wire signed [31:0] actual_pos;
    wire [31:0] reg_rdata_r, max_speed_r, accel_r, decel_r;
    wire reg_rvalid_r, cmd_update_r, move_start_r, not_ready_fault_r;
    wire signed [15:0] dac_code_r;
    integer error_cnt = 0, checked = 0;
    longint cum, le, lv, e, s;
    reg [31:0] d;

    servo_axis_filter_loop #(.UPDATE_CYCLES(UC)) dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_r, .reg_rvalid_r, .prof_valid, .prof_has_speed, .prof_speed, .prof_has_accel, .prof_accel,
        .prof_has_gains, .prof_p_gain, .prof_i_gain, .prof_d_gain, .prof_has_hold, .prof_hold_mode,
        .prof_deadband, .decel_wr, .decel_wdata, .move_req, .move_done, .actual_pos, .intended_pos, .intended_vel,
        .dac_code_r, .cmd_update_r, .move_start_r, .not_ready_fault_r, .max_speed_r, .accel_r, .decel_r);
    servo_drive_model drive_u (.ref_clk, .dac_code(dac_code_r), .cmd_update(cmd_update_r), .set_en, .set_val,
        .pos_r(actual_pos));

    initial forever #20 ref_clk = ~ref_clk;

    // --------------------
    // Shared tasks
    // --------------------
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input [15:0] a, input [31:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask
    task rd(input [15:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        tick;
        reg_rd = 1'b0;
        chk(reg_rvalid_r, 32'h1);
        d = reg_rdata_r;
        tick;
    endtask
    task put(input signed [31:0] v);
        set_val = v;
        set_en = 1'b1;
        tick;
        set_en = 1'b0;
    endtask
    task rst_dut(input signed [31:0] p0);
        rst = 1'b1;
        put(p0);
        repeat (3) tick;
        rst = 1'b0;
        cum = 0;
        le = 0;
        lv = 0;
    endtask
    task prof(input [3:0] h, input [31:0] sp, input [31:0] ac, input [7:0] p, input [1:0] hm, input [31:0] db);
        {prof_has_speed, prof_has_accel, prof_has_gains, prof_has_hold} = h;
        prof_speed = sp;
        prof_accel = ac;
        prof_p_gain = p;
        prof_hold_mode = hm;
        prof_deadband = db;
        prof_valid = 1'b1;
        tick;
        prof_valid = 1'b0;
        tick;
    endtask
    task wait_upd;
        integer n;
        n = 0;
        tick;
        while (cmd_update_r !== 1'b1 && n < 3 * UC) begin
            tick;
            n = n + 1;
        end
        chk(cmd_update_r, 32'h1);
        e = actual_pos - intended_pos;
    endtask
    function [15:0] sat(input longint v);
        v = v >>> 8;
        sat = v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 : v[15:0];
    endfunction
    task final_report;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task regs;
        rst_dut(0);
        rd(`ADDR_FILTER_SEL);
        chk(d, 32'h0);
        wr(`ADDR_VEL_FF_GAIN, 32'h5a5a1234);
        rd(`ADDR_VEL_FF_GAIN);
        chk(d, 32'h5a5a1234);
        wr(`ADDR_MOTION_STATE, 32'hffffffff);
        rd(`ADDR_MOTION_STATE);
        chk({29'h0, d[3:2], d[0]}, 32'h0);
        rd(16'h0100);
        chk(d, 32'h0);
    endtask
    task ramps;
        rst_dut(0);
        move_req = 1'b1;
        tick;
        move_req = 1'b0;
        chk(not_ready_fault_r, 32'h1);
        chk(move_start_r, 32'h0);
        prof(4'hc, 32'h3e8, 32'h1388, 8'h01, 2'h0, 32'h0);
        chk(not_ready_fault_r, 32'h0);
        chk(max_speed_r, 32'h3e8);
        chk(decel_r, 32'h1388);
        decel_wdata = 32'h7d0;
        decel_wr = 1'b1;
        tick;
        decel_wr = 1'b0;
        move_req = 1'b1;
        tick;
        move_req = 1'b0;
        chk(decel_r, 32'h7d0);
        chk(move_start_r, 32'h1);
        prof(4'h8, 32'h309, 32'h0, 8'h01, 2'h0, 32'h0);
        chk(max_speed_r, 32'h309);
        chk(accel_r, 32'h1388);
        chk(decel_r, 32'h7d0);
        move_done = 1'b1;
        tick;
        move_done = 1'b0;
    endtask
    task modes;
        integer k, u, sel;
        longint pe, ig, dg;
        for (k = 0; k < 5; k = k + 1) begin
            sel = k == 0 ? 0 : k == 1 ? 3 : k == 2 ? 5 : k - 2;
            pe = k == 1 ? 1 : 200;
            ig = k == 1 ? 0 : 3;
            dg = k == 1 ? 255 : 7;
            prof_i_gain = ig[7:0];
            prof_d_gain = dg[7:0];
            rst_dut(500);
            wr(`ADDR_FILTER_SEL, sel);
            wr(`ADDR_VEL_FF_GAIN, 32'h4d2);
            wr(`ADDR_ACC_FF_GAIN, 32'h40);
            if (sel == 1 || sel == 2) begin
                wait_upd;
                chk(dac_code_r[15:0], 32'h0);
            end
            prof(4'hf, 32'h3e8, 32'h1388, k == 1 ? 8'h00 : 8'hc8, 2'h0, 32'h0);
            for (u = 0; u < 3; u = u + 1) begin
                wait_upd;
                if (sel == 1 || sel == 2) begin
                    s = (sel * 2468 - 3702) * 256;
                end else if (sel == 5) begin
                    s = pe * e + 64 * (100 - lv) + 1234 * 100;
                end else begin
                    s = pe * e + dg * (e - le) + ig * cum;
                end
                chk(dac_code_r[15:0], sat(s));
                cum = cum + e;
                le = e;
                lv = 100;
                if (u == 1) begin
                    put(2000000);
                end
            end
        end
    endtask
    task holds;
        rst_dut(30);
        prof(4'h3, 32'h0, 32'h0, 8'hc8, 2'h1, 32'h32);
        wait_upd;
        chk(dac_code_r[15:0], 32'h0);
        put(5000);
        wait_upd;
        chk({31'h0, dac_code_r != 16'h0}, 32'h1);
        rst_dut(5000);
        prof(4'h3, 32'h0, 32'h0, 8'hc8, 2'h2, 32'h0);
        wait_upd;
        chk(dac_code_r[15:0], 32'h0);
    endtask

    initial begin
        regs;
        ramps;
        modes;
        holds;
        final_report;
    end

    // Watchdog: the scenarios need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule // servo_axis_filter_loop_test

// File: testbench/servo_drive_model.sv
// Servo drive and encoder model: each command update without set_en subtracts the code shifted right by SHIFT from the position
`timescale 1ns/1ps

module servo_drive_model #(
    parameter SHIFT = 6
) (
    input wire ref_clk,
    input wire signed [15:0] dac_code,
    input wire cmd_update,
    input wire set_en,
    input wire signed [31:0] set_val,
    output reg signed [31:0] pos_r
);
    initial pos_r = 32'sh0;
    always @(posedge ref_clk) begin
        if (set_en) begin
            pos_r <= set_val;
        end else if (cmd_update) begin
            pos_r <= pos_r - (dac_code >>> SHIFT);
        end
    end
endmodule // servo_drive_model
